// ### verilog/isl_pkg.sv
// Constants shared by the serial hex-loader host controller
package isl_pkg;
  // ---------------------------------------------------------------
  // Link timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int BAUD_HZ = 115200;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_CYCLES = 16'(CLK_HZ / BAUD_HZ / 2);
  localparam logic [3:0] FRAME_BITS = 4'h9;
  // ---------------------------------------------------------------
  // Characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_SYNC = 8'h55;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_ERR_SUM = 8'h58;
  localparam logic [7:0] CH_ERR_READ = 8'h4c;
  localparam logic [7:0] CH_ERR_PROG = 8'h50;
  localparam logic [7:0] CH_OK = 8'h2e;
  // ---------------------------------------------------------------
  // Register offsets of the controller
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_LEN = 4'h2;
  localparam logic [3:0] OFS_ADDR = 4'h3;
  localparam logic [3:0] OFS_TYPE = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h5;
  localparam logic [3:0] OFS_REPLY = 4'h6;
  localparam logic [3:0] OFS_RXDATA = 4'h7;
  localparam logic [3:0] OFS_LOCK = 4'h8;
  // Control bits
  localparam int CTRL_BOOT = 0;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_SEND = 2;
  localparam int CTRL_LINE = 3;
  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_REPLY = 1;
  localparam int ST_RXDATA = 2;
  // Record buffer depth (bytes of data per record)
  localparam int DATA_DEPTH = 16;
  // Lock level bits and security levels
  localparam logic [2:0] LOCK_L1 = 3'h7;
  localparam int LOCK_BIT_L2 = 0;
  localparam int LOCK_BIT_L3 = 1;
  localparam int LOCK_BIT_L4 = 2;
  // Boot vector value for loader entry
  localparam logic [2:0] BOOT_VEC_LOADER = 3'h3;
  localparam logic [15:0] LOADER_ENTRY = 16'h0000;
  // Fuse access codes for the flash control register
  localparam logic [7:0] FC_SEC_WRITE = 8'h0c;
  localparam logic [7:0] FC_SEC_READ = 8'h04;
  localparam logic [7:0] FC_CFG_WRITE = 8'h0d;
  localparam logic [7:0] FC_CFG_READ = 8'h05;
  localparam logic [7:0] FC_SEC_KEY1 = 8'h54;
  localparam logic [7:0] FC_SEC_KEY2 = 8'ha4;
  localparam logic [7:0] FC_CFG_KEY1 = 8'h55;
  localparam logic [7:0] FC_CFG_KEY2 = 8'ha5;
endpackage

// ### verilog/isl_uart_tx.sv
// Serial transmitter, 8N1, fixed bit time
`timescale 1ns/1ps
module isl_uart_tx
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte in
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  // Line
  output logic txd
);
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;

  // Shift out start, data LSB first, stop; line idles high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 9'h1ff;
      busy <= 1'b0;
      txd <= 1'b1;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        txd <= 1'b0;
        shift_reg <= {1'b1, data};
        cnt_reg <= BIT_CYCLES - 16'h0001;
        bit_reg <= 4'h0;
      end
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end else if (bit_reg == FRAME_BITS) begin
      busy <= 1'b0;
    end else begin
      txd <= shift_reg[0];
      shift_reg <= {1'b1, shift_reg[8:1]};
      bit_reg <= bit_reg + 4'h1;
      cnt_reg <= BIT_CYCLES - 16'h0001;
    end
  end
endmodule

// ### verilog/isl_uart_rx.sv
// Serial receiver, 8N1, three-stage input synchroniser
`timescale 1ns/1ps
module isl_uart_rx
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Line
  input wire logic rxd,
  // Byte out
  output logic valid,
  output logic [7:0] data
);
  logic s1_reg, s2_reg, s3_reg, line_reg;
  logic active_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;

  // Synchroniser; the line counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      line_reg <= 1'b1;
    end else begin
      s1_reg <= rxd;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) line_reg <= s3_reg;
    end
  end

  // Falling edge starts a frame, sample at mid bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      valid <= 1'b0;
      data <= 8'h00;
    end else begin
      valid <= 1'b0;
      if (!active_reg) begin
        if (!line_reg) begin
          active_reg <= 1'b1;
          cnt_reg <= HALF_CYCLES;
          bit_reg <= 4'h0;
        end
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else if (bit_reg == FRAME_BITS) begin
        // Stop bit; a low stop is a framing error and is dropped
        active_reg <= 1'b0;
        if (line_reg) begin
          valid <= 1'b1;
          data <= shift_reg;
        end
      end else begin
        if (bit_reg != 4'h0) shift_reg <= {line_reg, shift_reg[7:1]};
        bit_reg <= bit_reg + 4'h1;
        cnt_reg <= BIT_CYCLES - 16'h0001;
      end
    end
  end
endmodule

// ### verilog/isl_host.sv
// Host controller that drives a serial hex-record loader
//
// How it works
// - Security fuse write: 0x0C, 54h, A4h
// - Security fuse read: 04h, read, clear
// - Config fuse write: 0x0D, 55h, A5h
// - Config fuse read: 05h, read, clear
// - Lines idle high, falling edge starts frame
// - Link is 8N1, no flow, host baud
// - Host sends U first after reset; here U goes out only when software writes CTRL_SYNC
// - Frame: colon, len, offset, type, data, sum
// - Length counts data bytes only
// - Bytes after colon sent as two hex digits
// - Checksum makes full byte sum zero
`timescale 1ns/1ps
module isl_host
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Boot strap pins driven during device reset
  output logic ext_access_out,
  output logic prog_strobe_out,
  // Serial lines to the device
  output logic txd_primary,
  output logic txd_debug,
  input wire logic rxd_primary,
  input wire logic rxd_debug
);
  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ISL_IDLE = 7'h01,
    ISL_COLON = 7'h02,
    ISL_HI = 7'h04,
    ISL_LO = 7'h08,
    ISL_WAIT = 7'h10,
    ISL_SYNC = 7'h20,
    ISL_DONE = 7'h40
  } isl_state_e;

  isl_state_e state_reg;
  logic [7:0] len_reg, type_reg, sum_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_mem [DATA_DEPTH];
  logic [3:0] wptr_reg;
  logic [4:0] byte_idx_reg;
  logic [7:0] cur_byte;
  logic line_sel_reg, boot_reg;
  logic [7:0] reply_reg, rxdata_reg, lock_reg;
  logic reply_flag_reg, rxdata_flag_reg;
  logic tx_start_reg;
  logic [7:0] tx_data_reg;
  logic tx_busy, rx_valid;
  logic [7:0] rx_data;
  logic txd_line, rxd_sel;
  logic set_reply, set_rxdata, clr_reply, clr_rxdata;
  logic start_cmd, sync_cmd;

  // ---------------------------------------------------------------
  // Serial engines
  // ---------------------------------------------------------------
  // Lines idle high so the device sees a clean start edge
  // One fixed 8N1 bit time, picked by the host
  // A fixed rate will do: the device times our first character
  isl_uart_tx u_tx (
    .clk(clk),
    .nrst(nrst),
    .start(tx_start_reg),
    .data(tx_data_reg),
    .busy(tx_busy),
    .txd(txd_line)
  );

  // Switching lines mid-character garbles it; switch when quiet
  // Listen only on the selected line
  assign rxd_sel = line_sel_reg ? rxd_debug : rxd_primary;

  isl_uart_rx u_rx (
    .clk(clk),
    .nrst(nrst),
    .rxd(rxd_sel),
    .valid(rx_valid),
    .data(rx_data)
  );

  // Only the chosen line toggles; the device takes the first active
  // line it sees while polling both
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txd_primary <= 1'b1;
      txd_debug <= 1'b1;
    end else begin
      txd_primary <= line_sel_reg ? 1'b1 : txd_line;
      txd_debug <= line_sel_reg ? txd_line : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Boot strap
  // ---------------------------------------------------------------
  // Strap external access high and program strobe low while the
  // device is held in reset, asking for the loader entry at address
  // zero of the boot ROM
  // The straps count only while the device sits in reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_access_out <= 1'b0;
      prog_strobe_out <= 1'b1;
    end else begin
      ext_access_out <= boot_reg;
      prog_strobe_out <= !boot_reg;
    end
  end

  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  // One frame at a time: writes during a frame are dropped, so
  // software polls busy before loading the next record
  assign start_cmd = reg_wr && reg_addr == OFS_CTRL &&
                     reg_wdata[CTRL_SEND] && state_reg == ISL_IDLE;
  assign sync_cmd = reg_wr && reg_addr == OFS_CTRL &&
                    reg_wdata[CTRL_SYNC] && state_reg == ISL_IDLE;

  // Byte of the frame at the current index: len, offset, type, data
  // then the checksum; length counts data only
  always_comb begin
    cur_byte = 8'h00;
    case (byte_idx_reg)
      5'h00: cur_byte = len_reg;
      5'h01: cur_byte = addr_reg[15:8];
      5'h02: cur_byte = addr_reg[7:0];
      5'h03: cur_byte = type_reg;
      default: begin
        if (byte_idx_reg - 5'h04 < {1'b0, len_reg[3:0]})
          cur_byte = data_mem[4'(byte_idx_reg - 5'h04)];
        else
          cur_byte = 8'(~sum_reg + 8'h01);
      end
    endcase
  end

  // Hex digit of a nibble, upper case
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? 8'(8'h30 + {4'h0, n}) :
                            8'(8'h37 + {4'h0, n});
  endfunction

  // Sequence the frame one character at a time, waiting on the
  // transmitter so no character is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ISL_IDLE;
      byte_idx_reg <= 5'h00;
      sum_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else begin
      tx_start_reg <= 1'b0;
      case (state_reg)
        ISL_IDLE: begin
          if (sync_cmd) begin
            state_reg <= ISL_SYNC;
          end else if (start_cmd) begin
            byte_idx_reg <= 5'h00;
            sum_reg <= 8'h00;
            state_reg <= ISL_COLON;
          end
        end
        ISL_SYNC: begin
          // Baud is timed by the device on this character
          // Its alternate bits give a clean bit time
          if (!tx_busy && !tx_start_reg) begin
            tx_data_reg <= CH_SYNC;
            tx_start_reg <= 1'b1;
            state_reg <= ISL_DONE;
          end
        end
        ISL_COLON: begin
          // Colon marks the frame; the device skips anything before it
          if (!tx_busy && !tx_start_reg) begin
            tx_data_reg <= CH_COLON;
            tx_start_reg <= 1'b1;
            state_reg <= ISL_HI;
          end
        end
        ISL_HI: begin
          // Each byte goes out as two ASCII hex digits
          if (!tx_busy && !tx_start_reg) begin
            tx_data_reg <= hex_char(cur_byte[7:4]);
            tx_start_reg <= 1'b1;
            state_reg <= ISL_LO;
          end
        end
        ISL_LO: begin
          if (!tx_busy && !tx_start_reg) begin
            tx_data_reg <= hex_char(cur_byte[3:0]);
            tx_start_reg <= 1'b1;
            sum_reg <= 8'(sum_reg + cur_byte);
            if (byte_idx_reg == 5'(5'h04 + {1'b0, len_reg[3:0]}))
              state_reg <= ISL_DONE;
            else begin
              byte_idx_reg <= byte_idx_reg + 5'h01;
              state_reg <= ISL_HI;
            end
          end
        end
        ISL_DONE: begin
          if (!tx_busy && !tx_start_reg) state_reg <= ISL_IDLE;
        end
        default: state_reg <= ISL_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reply capture
  // ---------------------------------------------------------------
  // Reply letters X, L, P and dot end a command; CR and LF that
  // trail each reply are dropped
  assign set_reply = rx_valid && (rx_data == CH_ERR_SUM ||
                     rx_data == CH_ERR_READ || rx_data == CH_ERR_PROG ||
                     rx_data == CH_OK);
  // Anything else before the dot is read data
  assign set_rxdata = rx_valid && !set_reply &&
                      rx_data != CH_CR && rx_data != CH_LF;
  assign clr_reply = reg_rd && reg_addr == OFS_REPLY;
  assign clr_rxdata = reg_rd && reg_addr == OFS_RXDATA;

  // A reply not yet read is lost when the next one lands
  // Flags clear on read; a new character in that cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reply_reg <= 8'h00;
      rxdata_reg <= 8'h00;
      reply_flag_reg <= 1'b0;
      rxdata_flag_reg <= 1'b0;
    end else begin
      if (set_reply) begin
        reply_reg <= rx_data;
        reply_flag_reg <= 1'b1;
      end else if (clr_reply) reply_flag_reg <= 1'b0;
      if (set_rxdata) begin
        rxdata_reg <= rx_data;
        rxdata_flag_reg <= 1'b1;
      end else if (clr_rxdata) rxdata_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Record fields; held still while a frame is going out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      len_reg <= 8'h00;
      addr_reg <= 16'h0000;
      type_reg <= 8'h00;
      wptr_reg <= 4'h0;
      line_sel_reg <= 1'b0;
      boot_reg <= 1'b0;
      lock_reg <= LOCK_L1;
    end else if (reg_wr && state_reg == ISL_IDLE) begin
      case (reg_addr)
        OFS_CTRL: begin
          boot_reg <= reg_wdata[CTRL_BOOT];
          line_sel_reg <= reg_wdata[CTRL_LINE];
        end
        OFS_LEN: begin
          // Length takes the low four bits of the write only, at most 15 bytes
          len_reg <= {4'h0, reg_wdata[3:0]};
          wptr_reg <= 4'h0;
        end
        OFS_ADDR: addr_reg <= {addr_reg[7:0], reg_wdata};
        OFS_TYPE: type_reg <= reg_wdata;
        OFS_DATA: wptr_reg <= wptr_reg + 4'h1;
        // Fuse bytes are set by code on the device, not over the
        // link; only the lock level is mirrored here
        // Lock copy: bits only fall; raising needs an erase
        OFS_LOCK: lock_reg <= {5'h00, lock_reg[2:0] & reg_wdata[2:0]};
        default: ;
      endcase
    end
  end

  // Data buffer, addressed by the write pointer
  // No reset: bytes past the length are never sent
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == OFS_DATA && state_reg == ISL_IDLE)
      data_mem[wptr_reg] <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: reg_rdata <= {4'h0, line_sel_reg, 2'h0, boot_reg};
        OFS_STATUS: reg_rdata <= {5'h00, rxdata_flag_reg,
                                  reply_flag_reg, state_reg != ISL_IDLE};
        OFS_LEN: reg_rdata <= len_reg;
        OFS_ADDR: reg_rdata <= addr_reg[7:0];
        OFS_TYPE: reg_rdata <= type_reg;
        OFS_REPLY: reg_rdata <= reply_reg;
        OFS_RXDATA: reg_rdata <= rxdata_reg;
        OFS_LOCK: reg_rdata <= lock_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// ### tb/isl_dev_model.sv
// Behavioural serial loader device facing the host controller
`timescale 1ns/1ps
module isl_dev_model
  import isl_pkg::*;
#(
  parameter logic [2:0] BOOT_VEC = 3'h7
)
(
  // Clock, boot strap pins and lock level
  input wire logic clk,
  input wire logic ext_access,
  input wire logic prog_strobe,
  input wire logic [2:0] lock_bits,
  // Serial lines, a is primary and b is debug
  input wire logic rxd_a,
  input wire logic rxd_b,
  output logic txd_a,
  output logic txd_b
);
  // ------------------------------------------------------------
  // Character level
  // ------------------------------------------------------------
  int bit_t;
  logic sel_b;
  logic [7:0] ch;
  logic [7:0] hi;
  logic [7:0] by;
  logic [7:0] sum;
  logic [7:0] rep;
  logic [7:0] fld[$];
  wire rxd = sel_b ? rxd_b : rxd_a;

  // Upper-case ASCII hex digit to nibble
  function automatic logic [3:0] hexv(input logic [7:0] c);
    return (c > 8'h39) ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction

  // Receive one character; ends mid stop bit so bit 7 low is not a start
  task automatic rx_char(output logic [7:0] c);
    wait (rxd === 1'b0);
    repeat (bit_t / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_t) @(posedge clk);
      c[i] = rxd;
    end
    repeat (bit_t) @(posedge clk);
  endtask

  // Two digits make one byte, summed for the checksum
  task automatic rx_byte(output logic [7:0] b);
    rx_char(hi);
    rx_char(ch);
    b = {hexv(hi), hexv(ch)};
    sum = sum + b;
  endtask

  // Send one character on the chosen line, idle high afterwards
  task automatic tx_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (sel_b)
        txd_b <= f[i];
      else
        txd_a <= f[i];
      repeat (bit_t) @(posedge clk);
    end
  endtask

  // ------------------------------------------------------------
  // Loader: entry, line choice, autobaud, one reply per frame
  // ------------------------------------------------------------
  initial begin
    txd_a = 1'b1;
    txd_b = 1'b1;
    wait ((ext_access === 1'b1 && prog_strobe === 1'b0)
          || BOOT_VEC == BOOT_VEC_LOADER);
    wait (rxd_a === 1'b0 || rxd_b === 1'b0);
    sel_b = (rxd_a !== 1'b0);
    bit_t = 0;
    while (rxd === 1'b0) begin
      @(posedge clk);
      bit_t++;
    end
    repeat (bit_t / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      ch[i] = rxd;
      repeat (bit_t) @(posedge clk);
    end
    wait (ch === CH_SYNC);
    forever begin
      rx_char(ch);
      if (ch === CH_COLON) begin
        sum = 8'h00;
        fld.delete();
        repeat (4) begin
          rx_byte(by);
          fld.push_back(by);
        end
        repeat (int'(fld[0]) + 1) rx_byte(by);
        rep = CH_OK;
        if (fld[3] == 8'h04 && lock_bits[2:1] != 2'h3)
          rep = CH_ERR_READ;
        if (fld[3] == 8'h00 && lock_bits != LOCK_L1)
          rep = CH_ERR_PROG;
        if (sum != 8'h00)
          rep = CH_ERR_SUM;
        tx_char(rep);
        tx_char(CH_CR);
        tx_char(CH_LF);
      end
    end
  end
endmodule

// ### tb/isl_host_sva.sv
// Assertions on the host controller's register port and serial lines
`timescale 1ns/1ps
module isl_host_sva
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Boot strap pins and serial lines
  input wire logic ext_access_out,
  input wire logic prog_strobe_out,
  input wire logic txd_primary,
  input wire logic txd_debug
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [15:0] low_len;
  logic [15:0] high_len;
  logic [2:0] lock_seen;
  logic lock_rd_q;

  // Run lengths on the primary line; high saturates so reset reads idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_len <= 16'h0000;
      high_len <= 16'hffff;
    end else if (txd_primary) begin
      low_len <= 16'h0000;
      high_len <= (&high_len) ? high_len : high_len + 16'h0001;
    end else begin
      high_len <= 16'h0000;
      low_len <= low_len + 16'h0001;
    end
  end

  // Last lock copy seen on a read, starting at the unlocked level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_rd_q <= 1'b0;
      lock_seen <= LOCK_L1;
    end else begin
      lock_rd_q <= reg_rd && reg_addr == OFS_LOCK;
      if (lock_rd_q)
        lock_seen <= reg_rdata[2:0];
    end
  end

  sequence lock_read_s;
    reg_rd && reg_addr == OFS_LOCK ##1 1'b1;
  endsequence
  sequence boot_set_s;
    reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_BOOT];
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  unmapped_rd_a:
    assert property (reg_rd && reg_addr > OFS_LOCK |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  lock_lower_a:
    assert property (lock_read_s |-> reg_rdata[7:3] == 5'h00
                     && (reg_rdata[2:0] & ~lock_seen) == 3'h0)
    else $error("lock copy bit rose");
  boot_pair_a:
    assert property (ext_access_out == !prog_strobe_out)
    else $error("boot strap pins not complementary");
  boot_follow_a:
    assert property (boot_set_s |-> ##[1:2] ext_access_out)
    else $error("boot request not driven");
  boot_cause_a:
    assert property ($rose(ext_access_out) |->
                     $past(reg_wr, 1) || $past(reg_wr, 2))
    else $error("boot request without write");
  line_excl_a:
    assert property (!(txd_primary == 1'b0 && txd_debug == 1'b0))
    else $error("both serial lines active");
  bit_time_a:
    assert property ($rose(txd_primary) |-> low_len % BIT_CYCLES == 16'h0)
    else $error("low run not whole bit times");
  low_max_a:
    assert property (!txd_primary |-> low_len < 16'(9) * BIT_CYCLES)
    else $error("line low beyond start and data bits");
  stop_len_a:
    assert property ($fell(txd_primary) |-> high_len >= BIT_CYCLES)
    else $error("stop or idle time too short");
endmodule

bind isl_host isl_host_sva u_isl_host_sva (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_access_out(ext_access_out), .prog_strobe_out(prog_strobe_out),
  .txd_primary(txd_primary), .txd_debug(txd_debug)
);

// ### tb/isl_host_tb.sv
// Self-checking bench: host controller against the loader model
`timescale 1ns/1ps
module isl_host_tb
  import isl_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk;
  logic nrst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic ext_access_out;
  logic prog_strobe_out;
  logic txd_primary;
  logic txd_debug;
  logic rxd_primary;
  logic rxd_debug;
  logic [2:0] dev_lock;
  int num_errors;
  int comparisons;

  isl_host u_isl_host (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_access_out(ext_access_out), .prog_strobe_out(prog_strobe_out),
    .txd_primary(txd_primary), .txd_debug(txd_debug),
    .rxd_primary(rxd_primary), .rxd_debug(rxd_debug)
  );
  isl_dev_model u_isl_dev_model (
    .clk(clk), .ext_access(ext_access_out), .prog_strobe(prog_strobe_out),
    .lock_bits(dev_lock), .rxd_a(txd_primary), .rxd_b(txd_debug),
    .txd_a(rxd_primary), .txd_b(rxd_debug)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; a quiet cycle after each keeps drivers race free
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask

  // Poll a status bit; a bounded count turns a hang into a failure
  task automatic wait_flag(input int b, input logic v);
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      reg_read(OFS_STATUS, s);
      n++;
      if (n > 200000) begin
        num_errors++;
        end_sim();
      end
    end while (s[b] !== v);
  endtask

  // Load one record, send it, and check the single-character answer
  task automatic frame(input logic [7:0] len, input logic [15:0] ofs,
                       input logic [7:0] typ, input logic [7:0] dat,
                       input logic [7:0] exp);
    wait_flag(ST_BUSY, 1'b0);
    reg_write(OFS_LEN, len);
    reg_write(OFS_ADDR, ofs[15:8]);
    reg_write(OFS_ADDR, ofs[7:0]);
    rd_check(OFS_ADDR, ofs[7:0]);
    reg_write(OFS_TYPE, typ);
    if (len != 8'h00)
      reg_write(OFS_DATA, dat);
    reg_write(OFS_CTRL, 8'h05);
    wait_flag(ST_REPLY, 1'b1);
    rd_check(OFS_REPLY, exp);
    // Let the trailing line ending land; it must raise no flag
    repeat (22 * int'(BIT_CYCLES)) @(posedge clk);
    rd_check(OFS_STATUS, 8'h00);
    $display("test frame type %h done", typ);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dev_lock = LOCK_L1;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check({7'h0, prog_strobe_out}, 8'h01);
    rd_check(OFS_LOCK, {5'h0, LOCK_L1});
    rd_check(4'hf, 8'h00);
    rd_check(OFS_STATUS, 8'h00);
    reg_write(OFS_LOCK, 8'h06);
    reg_write(OFS_LOCK, 8'h07);
    rd_check(OFS_LOCK, 8'h06);
    $display("test registers done");
    reg_write(OFS_CTRL, 8'h01);
    repeat (2) @(negedge clk);
    check({7'h0, ext_access_out}, 8'h01);
    check({7'h0, prog_strobe_out}, 8'h00);
    @(posedge clk);
    reg_write(OFS_CTRL, 8'h03);
    wait_flag(ST_BUSY, 1'b0);
    $display("test boot and sync done");
    frame(8'h01, 16'h0010, 8'h00, 8'hc3, CH_OK);
    dev_lock <= 3'h6;
    frame(8'h00, 16'h0000, 8'h00, 8'h00, CH_ERR_PROG);
    dev_lock <= 3'h5;
    frame(8'h00, 16'h0000, 8'h04, 8'h00, CH_ERR_READ);
    dev_lock <= 3'h3;
    frame(8'h00, 16'h0000, 8'h04, 8'h00, CH_ERR_READ);
    end_sim();
  end

  // Watchdog: four records at 115200 baud need about 5 ms
  initial begin
    #9_000_000;
    num_errors++;
    end_sim();
  end
endmodule
